// [rtl/sbtc_pkg.sv]
package sbtc_pkg;

  // register map, byte addresses on the register bus
  localparam int          ADDR_W         = 4;
  localparam int          DATA_W         = 32;
  localparam logic [3:0]  OFS_CONTROL    = 4'h0;
  localparam logic [3:0]  OFS_COUNT_LOW  = 4'h4;
  localparam logic [3:0]  OFS_COUNT_HIGH = 4'h8;
  localparam logic [3:0]  OFS_STATUS     = 4'hc;

  // control register fields
  localparam int          CTL_RUN        = 0;
  localparam int          CTL_SRC        = 1;
  localparam int          CTL_SYNC_BYP   = 2;
  localparam int          CTL_PAIR_LO    = 3;
  localparam int          CTL_PS_LO      = 4;
  localparam int          CTL_PS_HI      = 5;
  localparam int          CTL_PAIR_HI    = 6;
  localparam int          CTL_WIDE       = 7;

  // status register fields
  localparam int          STS_FLAG       = 0;
  localparam int          STS_IRQ_EN     = 1;

  // values after reset, and the count at which the counter wraps
  localparam logic [7:0]  CONTROL_RST    = 8'h00;
  localparam logic [15:0] COUNT_RST      = 16'h0000;
  localparam logic [15:0] COUNT_MAX      = 16'hffff;
  localparam logic [7:0]  BUFFER_RST     = 8'h00;
  localparam logic [2:0]  PRESCALE_RST   = 3'h0;

  // instruction cycle is the oscillator divided by four
  localparam int          INSTR_DIV      = 4;
  localparam logic [1:0]  INSTR_PHASE_LAST = 2'(INSTR_DIV - 1);
  localparam logic [1:0]  PHASE_RST      = 2'h0;

  // time base pairing codes and channel masks
  localparam int          NUM_CHANNELS   = 5;
  localparam logic [1:0]  PAIR_ALL_OTHER = 2'h0;
  localparam logic [1:0]  PAIR_SPLIT_LO  = 2'h1;
  localparam logic [1:0]  PAIR_SPLIT_HI  = 2'h2;
  localparam logic [1:0]  PAIR_ALL_THIS  = 2'h3;
  localparam logic [4:0]  MASK_NONE      = 5'h00;
  localparam logic [4:0]  MASK_SPLIT_LO  = 5'h1e;
  localparam logic [4:0]  MASK_SPLIT_HI  = 5'h1c;
  localparam logic [4:0]  MASK_ALL       = 5'h1f;

  typedef enum logic [1:0] {
    SBTC_MODE_TIMER,
    SBTC_MODE_SYNC_CNT,
    SBTC_MODE_ASYNC_CNT
  } sbtc_mode_t;

endpackage : sbtc_pkg

// [rtl/sbtc_pin_sync.sv]
`timescale 1ns/1ps
// two-stage synchroniser for pins entering the mclk domain
module sbtc_pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             mclk_in,
  input  wire logic             arst_n_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (ce_in) begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule : sbtc_pin_sync

// [rtl/sbtc_timer.sv]
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module sbtc_timer (
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  input  wire logic        ce_in,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        external_count_input_in,
  input  wire logic        lp_osc_clk_in,
  input  wire logic        lp_osc_enable_in,
  input  wire logic [1:0]  port_direction_bits_in,
  input  wire logic [1:0]  port_pin_in,
  output logic      [1:0]  port_dir_eff_out,
  output logic      [1:0]  port_read_out,
  input  wire logic [4:0]  special_event_in,
  output logic      [4:0]  channel_uses_this_pair_out,
  output logic             overflow_irq_out
);

  // terminal value of the prescale counter for a given field
  function automatic logic [2:0] ps_limit(input logic [1:0] sel);
    ps_limit = 3'((4'h1 << sel) - 4'h1);
  endfunction : ps_limit

  // channels that take their time base from this pair
  function automatic logic [4:0] pair_mask(input logic [1:0] code);
    case (code)
      sbtc_pkg::PAIR_ALL_THIS: pair_mask = sbtc_pkg::MASK_ALL;
      sbtc_pkg::PAIR_SPLIT_HI: pair_mask = sbtc_pkg::MASK_SPLIT_HI;
      sbtc_pkg::PAIR_SPLIT_LO: pair_mask = sbtc_pkg::MASK_SPLIT_LO;
      default:                 pair_mask = sbtc_pkg::MASK_NONE;
    endcase
  endfunction : pair_mask

  logic [7:0]  control_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0]  buffer_reg;
  logic [2:0]  prescale_reg;
  logic [2:0]  prescale_next;
  logic [1:0]  phase_reg;
  logic        pending_reg;
  logic        pending_next;
  logic        armed_reg;
  logic        armed_next;
  logic        ext_prev_reg;
  logic        flag_reg;
  logic        flag_next;
  logic        irq_en_reg;
  logic        irq_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  dir_eff_reg;
  logic [1:0]  port_read_reg;
  logic [4:0]  chan_reg;

  logic [3:0]  pin_sync;
  logic        ext_level;
  logic        ext_fall;
  logic        ext_rise;
  logic        ext_edge;
  logic        instr_tick;
  logic        src_tick;
  logic        count_en;
  logic        ps_wrap;
  logic        inc;
  logic        wrap;
  logic        sev_hit;
  logic        sev_clear;
  logic        run;
  logic        src_ext;
  logic        wide;
  logic [1:0]  ps_sel;
  logic [1:0]  pair_code;
  sbtc_pkg::sbtc_mode_t mode;

  logic        req;
  logic        accept;
  logic        be0;
  logic        sel_ctl;
  logic        sel_low;
  logic        sel_high;
  logic        sel_sts;
  logic        wr_ctl;
  logic        wr_low;
  logic        wr_high;
  logic        wr_sts;
  logic        rd_low;
  logic        sw_write;
  logic [7:0]  wbyte;
  logic [7:0]  high_view;
  logic [31:0] read_word;

  // pins: {port pins, oscillator, count input}
  sbtc_pin_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .ce_in     (ce_in),
    .async_in  ({port_pin_in, lp_osc_clk_in, external_count_input_in}),
    .sync_out  (pin_sync)
  );

  // control fields
  assign run       = control_reg[sbtc_pkg::CTL_RUN];
  assign src_ext   = control_reg[sbtc_pkg::CTL_SRC];
  assign wide      = control_reg[sbtc_pkg::CTL_WIDE];
  assign ps_sel    = control_reg[sbtc_pkg::CTL_PS_HI:sbtc_pkg::CTL_PS_LO];
  assign pair_code = {control_reg[sbtc_pkg::CTL_PAIR_HI], control_reg[sbtc_pkg::CTL_PAIR_LO]};

  // bypass bit only matters for the external source
  assign mode = !src_ext ? sbtc_pkg::SBTC_MODE_TIMER :
                control_reg[sbtc_pkg::CTL_SYNC_BYP] ? sbtc_pkg::SBTC_MODE_ASYNC_CNT :
                sbtc_pkg::SBTC_MODE_SYNC_CNT;

  // bus decode
  assign req      = avs_read | avs_write;
  assign accept   = req & ~ack_reg & ce_in;
  assign be0      = avs_byteenable[0];
  assign wbyte    = avs_writedata[7:0];
  assign sel_ctl  = avs_address == sbtc_pkg::OFS_CONTROL;
  assign sel_low  = avs_address == sbtc_pkg::OFS_COUNT_LOW;
  assign sel_high = avs_address == sbtc_pkg::OFS_COUNT_HIGH;
  assign sel_sts  = avs_address == sbtc_pkg::OFS_STATUS;
  assign wr_ctl   = accept & avs_write & be0 & sel_ctl;
  assign wr_low   = accept & avs_write & be0 & sel_low;
  assign wr_high  = accept & avs_write & be0 & sel_high;
  assign wr_sts   = accept & avs_write & be0 & sel_sts;
  assign rd_low   = accept & avs_read & sel_low;
  assign sw_write = wr_low | wr_high;

  // wide mode hides the live high byte behind the buffer
  assign high_view = wide ? buffer_reg : count_reg[15:8];

  assign read_word = sel_ctl  ? {24'h00_0000, control_reg} :
                     sel_low  ? {24'h00_0000, count_reg[7:0]} :
                     sel_high ? {24'h00_0000, high_view} :
                     sel_sts  ? {30'h0000_0000, irq_en_reg, flag_reg} :
                     32'h0000_0000;

  // first cycle of a request always waits, so effects happen exactly once
  assign avs_waitrequest = req & (~ack_reg | ~ce_in);
  assign avs_readdata    = rdata_reg;

  // external edge detection, armed by a falling edge first
  assign ext_level = lp_osc_enable_in ? pin_sync[1] : pin_sync[0];
  assign ext_fall  = ext_prev_reg & ~ext_level;
  assign ext_rise  = ~ext_prev_reg & ext_level;
  assign ext_edge  = armed_reg & ext_rise;
  assign armed_next = (!src_ext || !run || wr_low) ? 1'b0 :
                      ext_fall ? 1'b1 : armed_reg;

  // count clock per mode
  assign instr_tick = phase_reg == sbtc_pkg::INSTR_PHASE_LAST;
  always_comb begin
    case (mode)
      sbtc_pkg::SBTC_MODE_TIMER:     src_tick = instr_tick;
      sbtc_pkg::SBTC_MODE_SYNC_CNT:  src_tick = instr_tick & (pending_reg | ext_edge);
      sbtc_pkg::SBTC_MODE_ASYNC_CNT: src_tick = ext_edge;
      default:                       src_tick = 1'b0;
    endcase
  end

  // a synchronised edge waits for the next instruction cycle boundary
  assign pending_next = (mode == sbtc_pkg::SBTC_MODE_SYNC_CNT) & run & ~wr_low &
                        ~instr_tick & (pending_reg | ext_edge);

  assign count_en = run & src_tick;
  assign ps_wrap  = prescale_reg >= ps_limit(ps_sel);
  assign inc      = count_en & ps_wrap;

  assign prescale_next = wr_low ? sbtc_pkg::PRESCALE_RST :
                         !count_en ? prescale_reg :
                         ps_wrap ? sbtc_pkg::PRESCALE_RST : 3'(prescale_reg + 3'h1);

  // special event: only from channels on this pair, not in async mode
  assign sev_hit   = |(special_event_in & pair_mask(pair_code));
  assign sev_clear = sev_hit & (mode != sbtc_pkg::SBTC_MODE_ASYNC_CNT) & ~sw_write;

  // software write beats trigger, trigger beats increment
  always_comb begin
    count_next = count_reg;
    if (wr_low) begin
      count_next[7:0] = wbyte;
      if (wide) begin
        count_next[15:8] = buffer_reg;
      end
    end else if (wr_high) begin
      if (!wide) begin
        count_next[15:8] = wbyte;
      end
    end else if (sev_clear) begin
      count_next = sbtc_pkg::COUNT_RST;
    end else if (inc) begin
      count_next = 16'(count_reg + 16'h0001);
    end
  end

  // trigger clear suppresses the wrap, so no flag from it
  assign wrap      = inc & ~sw_write & ~sev_clear & (count_reg == sbtc_pkg::COUNT_MAX);
  // hardware set wins over a coincident software clear
  assign flag_next = wrap | (flag_reg & ~(wr_sts & wbyte[sbtc_pkg::STS_FLAG]));

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (ce_in) begin
      ack_reg <= accept;
      if (accept) begin
        rdata_reg <= read_word;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      control_reg <= sbtc_pkg::CONTROL_RST;
      irq_en_reg  <= 1'b0;
    end else if (ce_in) begin
      if (wr_ctl) begin
        control_reg <= wbyte;
      end
      if (wr_sts) begin
        irq_en_reg <= wbyte[sbtc_pkg::STS_IRQ_EN];
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      buffer_reg <= sbtc_pkg::BUFFER_RST;
    end else if (ce_in && wide) begin
      if (rd_low) begin
        buffer_reg <= count_reg[15:8];
      end else if (wr_high) begin
        buffer_reg <= wbyte;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_reg    <= sbtc_pkg::COUNT_RST;
      prescale_reg <= sbtc_pkg::PRESCALE_RST;
      flag_reg     <= 1'b0;
    end else if (ce_in) begin
      count_reg    <= count_next;
      prescale_reg <= prescale_next;
      flag_reg     <= flag_next;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_reg    <= sbtc_pkg::PHASE_RST;
      pending_reg  <= 1'b0;
      armed_reg    <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else if (ce_in) begin
      phase_reg    <= 2'(phase_reg + 2'h1);
      pending_reg  <= pending_next;
      armed_reg    <= armed_next;
      ext_prev_reg <= ext_level;
    end
  end

  // side outputs, registered so they never glitch
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dir_eff_reg   <= 2'h3;
      port_read_reg <= 2'h0;
      chan_reg      <= sbtc_pkg::MASK_NONE;
      irq_reg       <= 1'b0;
    end else if (ce_in) begin
      dir_eff_reg   <= lp_osc_enable_in ? 2'h3 : port_direction_bits_in;
      port_read_reg <= lp_osc_enable_in ? 2'h0 : pin_sync[3:2];
      chan_reg      <= pair_mask(pair_code);
      irq_reg       <= flag_reg & irq_en_reg;
    end
  end

  assign port_dir_eff_out           = dir_eff_reg;
  assign port_read_out              = port_read_reg;
  assign channel_uses_this_pair_out = chan_reg;
  assign overflow_irq_out           = irq_reg;

endmodule : sbtc_timer

// [verif/sbtc_timer_checker.sv]
`timescale 1ns/1ps
module sbtc_timer_checker (
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  input  wire logic        lp_osc_enable_in,
  input  wire logic [1:0]  port_direction_bits_in,
  input  wire logic [1:0]  port_dir_eff_out,
  input  wire logic [1:0]  port_read_out,
  input  wire logic [4:0]  channel_uses_this_pair_out,
  input  wire logic        overflow_irq_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  wire ctl_wr = avs_write && (avs_address == sbtc_pkg::OFS_CONTROL);

  read_answer_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait cycle");
  write_answer_a: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("write not answered after one wait cycle");
  data_hold_a: assert property (!(avs_read || avs_write) |=> $stable(avs_readdata))
    else $error("read data moved without a request");
  data_width_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  pin_dir_a: assert property (lp_osc_enable_in |=> port_dir_eff_out == 2'b11)
    else $error("oscillator pins not forced to input");
  pin_pass_a: assert property (!lp_osc_enable_in |=> port_dir_eff_out == $past(port_direction_bits_in))
    else $error("direction bits not passed through");
  pin_zero_a: assert property (lp_osc_enable_in |=> port_read_out == 2'b00)
    else $error("oscillator pins not read as zero");
  mask_legal_a: assert property (channel_uses_this_pair_out inside {5'h00, 5'h1e, 5'h1c, 5'h1f})
    else $error("channel mask not a pairing code");
  mask_cause_a: assert property ($changed(channel_uses_this_pair_out) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("channel mask changed without a control write");
  irq_fall_a: assert property ($fell(overflow_irq_out) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("interrupt dropped without a register write");
endmodule : sbtc_timer_checker

// [verif/sbtc_pin_model.sv]
`timescale 1ns/1ps
module sbtc_pin_model (
  input  wire logic mclk_in,
  output logic      count_pin_out,
  output logic      osc_pin_out
);
  // lines idle high, so every burst opens with the falling edge that arms counting
  initial begin
    count_pin_out = 1'b1;
    osc_pin_out   = 1'b1;
  end
  task automatic burst(input logic osc, input int n, input int half);
    for (int i = 0; i < n; i++) begin
      repeat (half) @(posedge mclk_in);
      if (osc) osc_pin_out <= 1'b0;
      else count_pin_out <= 1'b0;
      repeat (half) @(posedge mclk_in);
      if (osc) osc_pin_out <= 1'b1;
      else count_pin_out <= 1'b1;
    end
    // the last edge still has to cross the synchroniser
    repeat (8) @(posedge mclk_in);
  endtask : burst
endmodule : sbtc_pin_model

// [verif/test_sbtc_timer.sv]
`timescale 1ns/1ps
module test_sbtc_timer;
  localparam logic [3:0] A_CTL = sbtc_pkg::OFS_CONTROL;
  localparam logic [3:0] A_LOW = sbtc_pkg::OFS_COUNT_LOW;
  localparam logic [3:0] A_HIGH = sbtc_pkg::OFS_COUNT_HIGH;
  localparam logic [3:0] A_STS = sbtc_pkg::OFS_STATUS;
  logic        mclk_in, arst_n_in, avs_read, avs_write, avs_waitrequest;
  logic        lp_osc_enable_in, overflow_irq_out, ext_pin, osc_pin, ce_in;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0]  port_direction_bits_in, port_pin_in, port_dir_eff_out, port_read_out;
  logic [4:0]  special_event_in, channel_uses_this_pair_out;
  logic [4:0]  masks [4];
  logic [7:0]  exp_q [$];
  logic [1:0]  slack_q [$];
  string       name_q [$];
  logic [7:0]  e, c;
  logic [1:0]  s;
  int          fail_count, n_tests;

  sbtc_timer sbtc_timer_i (.mclk_in, .arst_n_in, .ce_in, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .external_count_input_in(ext_pin), .lp_osc_clk_in(osc_pin), .lp_osc_enable_in,
    .port_direction_bits_in, .port_pin_in, .port_dir_eff_out, .port_read_out,
    .special_event_in, .channel_uses_this_pair_out, .overflow_irq_out);
  sbtc_pin_model sbtc_pin_model_i (.mclk_in, .count_pin_out(ext_pin), .osc_pin_out(osc_pin));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // hold the request until an edge samples waitrequest low; the watchdog ends a hang
  task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= we;
    avs_read      <= !we;
    do begin
      @(posedge mclk_in);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input string w, input logic [3:0] a, input logic [7:0] x, input logic [1:0] k);
    name_q.push_back(w);
    exp_q.push_back(x);
    slack_q.push_back(k);
    bus(1'b0, a, 8'h00);
  endtask : rd
  // stop, zero the low byte (and so the prescaler), then start with the new control value
  task automatic restart(input logic [7:0] ctl);
    wr(A_CTL, 8'h00);
    wr(A_LOW, 8'h00);
    wr(A_CTL, ctl);
  endtask : restart
  task automatic fire();
    @(posedge mclk_in);
    special_event_in <= 5'(1 << ($urandom % 5));
    @(posedge mclk_in);
    special_event_in <= 5'h00;
  endtask : fire

  // read data is taken at the edge that samples waitrequest low
  always @(posedge mclk_in) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) check("unexpected read", 32'h1, 32'h0);
      else begin
        e = exp_q.pop_front();
        s = slack_q.pop_front();
        if (avs_readdata >= {24'h0, e} && avs_readdata <= {24'h0, e} + s) check(name_q.pop_front(), {24'h0, e}, {24'h0, e});
        else check(name_q.pop_front(), avs_readdata, {24'h0, e});
      end
    end
  end

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (30000) @(posedge mclk_in);
    fail_count++;
    conclude();
  end

  initial begin
    fail_count = 0;
    n_tests = 0;
    arst_n_in = 1'b0;
    ce_in = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {lp_osc_enable_in, port_direction_bits_in, port_pin_in, special_event_in} = '0;
    masks = '{sbtc_pkg::MASK_NONE, sbtc_pkg::MASK_SPLIT_LO, sbtc_pkg::MASK_SPLIT_HI, sbtc_pkg::MASK_ALL};
    void'($urandom(32'hddd4_eefe));
    repeat (3) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    rd("control reset", A_CTL, sbtc_pkg::CONTROL_RST, 0);
    rd("status reset", A_STS, 8'h00, 0);
    wr(4'h2, 8'hff);
    rd("unmapped", 4'h2, 8'h00, 0);
    for (int p = 0; p < 4; p++) begin
      c = (8'($urandom) & 8'h36) | {1'b0, p[1], 2'b00, p[0], 3'b000};
      wr(A_CTL, c);
      rd("control", A_CTL, c, 0);
      check("pairing mask", channel_uses_this_pair_out, masks[p]);
    end
    c = 8'($urandom);
    port_direction_bits_in <= c[1:0];
    port_pin_in <= c[3:2];
    repeat (5) @(posedge mclk_in);
    check("pin dir", port_dir_eff_out, c[1:0]);
    check("pin read", port_read_out, c[3:2]);
    wr(A_CTL, 8'h80);
    wr(A_HIGH, 8'h12);
    wr(A_LOW, 8'h34);
    rd("wide low", A_LOW, 8'h34, 0);
    rd("wide high", A_HIGH, 8'h12, 0);
    wr(A_HIGH, 8'h56);
    rd("buffer", A_HIGH, 8'h56, 0);
    wr(A_CTL, 8'h00);
    rd("live high", A_HIGH, 8'h12, 0);
    for (int p = 0; p < 4; p++) begin
      restart(8'h07 | 8'(p << 4));
      sbtc_pin_model_i.burst(1'b0, 16, 3);
      rd("async count", A_LOW, 8'(16 >> p), 0);
    end
    restart(8'h37);
    sbtc_pin_model_i.burst(1'b0, 4, 3);
    wr(A_HIGH, 8'h00);
    sbtc_pin_model_i.burst(1'b0, 4, 3);
    rd("prescaler kept", A_LOW, 8'h01, 0);
    // edges seen while the clock enable is low must be lost entirely
    restart(8'h07);
    ce_in <= 1'b0;
    sbtc_pin_model_i.burst(1'b0, 4, 3);
    ce_in <= 1'b1;
    rd("frozen", A_LOW, 8'h00, 0);
    restart(8'h03);
    sbtc_pin_model_i.burst(1'b0, 5, 6);
    rd("sync count", A_LOW, 8'h05, 0);
    lp_osc_enable_in <= 1'b1;
    restart(8'h07);
    sbtc_pin_model_i.burst(1'b1, 3, 4);
    rd("osc count", A_LOW, 8'h03, 0);
    check("osc dir", port_dir_eff_out, 2'b11);
    check("osc read", port_read_out, 2'b00);
    lp_osc_enable_in <= 1'b0;
    restart(8'h11);
    repeat (160) @(posedge mclk_in);
    wr(A_CTL, 8'h10);
    rd("timer count", A_LOW, 8'd19, 2);
    wr(A_LOW, 8'h07);
    repeat (40) @(posedge mclk_in);
    rd("stopped", A_LOW, 8'h07, 0);
    wr(A_STS, 8'h03);
    wr(A_HIGH, 8'hff);
    wr(A_LOW, 8'hfe);
    wr(A_CTL, 8'h01);
    repeat (16) @(posedge mclk_in);
    check("irq", overflow_irq_out, 1'b1);
    wr(A_STS, 8'h00);
    rd("masked flag", A_STS, 8'h01, 0);
    check("masked irq", overflow_irq_out, 1'b0);
    wr(A_STS, 8'h03);
    rd("flag cleared", A_STS, 8'h02, 0);
    rd("wrapped", A_HIGH, 8'h00, 0);
    wr(A_CTL, 8'h49);
    wr(A_HIGH, 8'hff);
    fire();
    rd("event clear", A_HIGH, 8'h00, 0);
    rd("no flag", A_STS, 8'h02, 0);
    wr(A_CTL, 8'h4f);
    wr(A_HIGH, 8'h33);
    fire();
    rd("async kept", A_HIGH, 8'h33, 0);
    conclude();
  end
endmodule : test_sbtc_timer

bind sbtc_timer sbtc_timer_checker sbtc_timer_checker_i (.mclk_in, .arst_n_in, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .lp_osc_enable_in,
  .port_direction_bits_in, .port_dir_eff_out, .port_read_out, .channel_uses_this_pair_out,
  .overflow_irq_out);
